// [rtl/ocp_pkg.sv]
package ocp_pkg;
  // clock and timing
  localparam int CLK_NS = 100;
  localparam int RETRY_LONG_MS = 4;
  localparam int RETRY_SHORT_US = 50;
  localparam int RETRY_LONG_CYC =
    (RETRY_LONG_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_SHORT_CYC =
    (RETRY_SHORT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int DEG_STEP_US = 2;
  localparam int DEG_STEP_CYC = (DEG_STEP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_BASE_NS = 50;
  localparam int TMR_W = 16;
  localparam int DEG_W = 7;

  // bus and register indices; byte address is four times the index
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam logic [5:0] OCP_IDX = 6'h05;
  localparam logic [5:0] AMP_IDX = 6'h06;
  localparam logic [5:0] CTL_IDX = 6'h07;
  localparam logic [5:0] STAT_IDX = 6'h08;

  // reset values
  localparam logic [10:0] OCP_RST = 11'h159;
  localparam logic [10:0] AMP_RST = 11'h283;
  localparam logic [10:0] CTL_RST = 11'h001;
  localparam logic [10:0] CTL_MASK = 11'h001;
  // gap output in reset matches the default 100 ns code
  localparam logic [2:0] DEAD_RST = 3'h1;

  // overcurrent settings fields
  localparam int RETRY_BIT = 10;
  localparam int DEAD_LSB = 8;
  localparam int MODE_LSB = 6;
  localparam int DEG_LSB = 4;
  localparam int DSLVL_LSB = 0;

  // amplifier settings fields
  localparam int INSEL_BIT = 10;
  localparam int HALF_BIT = 9;
  localparam int LSP_BIT = 8;
  localparam int GAIN_LSB = 6;
  localparam int SDIS_BIT = 5;
  localparam int CAL_A_BIT = 4;
  localparam int CAL_B_BIT = 3;
  localparam int CAL_C_BIT = 2;
  localparam int SLVL_LSB = 0;

  // control fields
  localparam int PCC_BIT = 0;
  localparam int CLR_BIT = 1;

  typedef enum logic [1:0] {
    MODE_LATCH = 2'b00,
    MODE_RETRY = 2'b01,
    MODE_REPORT = 2'b10,
    MODE_SILENT = 2'b11
  } overcurrent_response_sel_e;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'b001,
    ST_LATCHED = 3'b010,
    ST_RETRY = 3'b100
  } fault_state_e;

  function automatic logic [10:0] merge11(input logic [10:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge11 = old;
    if (s[0]) merge11[7:0] = d[7:0];
    if (s[1]) merge11[10:8] = d[10:8];
  endfunction : merge11

  function automatic logic [DEG_W-1:0] deg_cycles(input logic [1:0] sel);
    deg_cycles = DEG_W'((int'(sel) + 1) * DEG_STEP_CYC);
  endfunction : deg_cycles

  // gaps below one clock period still take one whole cycle
  function automatic logic [2:0] dead_cycles(input logic [1:0] sel);
    int cyc;
    cyc = ((DEAD_BASE_NS << sel) + CLK_NS - 1) / CLK_NS;
    if (cyc < 1) cyc = 1;
    dead_cycles = 3'(cyc);
  endfunction : dead_cycles
endpackage : ocp_pkg

// [rtl/prot_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface prot_if;
  logic [1:0] filter_sel;
  logic [1:0] raw;
  wire logic [1:0] filtered;
  logic retry_sel;
  logic start;
  logic stop;
  logic expired;
  logic running;
  modport filt (input filter_sel, input raw, output filtered);
  modport tmr (input retry_sel, input start, input stop,
               output expired, output running);
  modport ctl (output filter_sel, output raw, input filtered,
               output retry_sel, output start, output stop,
               input expired, input running);
endinterface : prot_if
`default_nettype wire

// [rtl/overcurrent_filter.sv]
`timescale 1ns/10ps
`default_nettype none
module overcurrent_filter (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // selection and comparators
  prot_if.filt pif
);
  import ocp_pkg::*;

  logic [DEG_W-1:0] thr;
  assign thr = deg_cycles(pif.filter_sel);

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [DEG_W-1:0] cnt_r;
    logic [DEG_W-1:0] cnt_nxt;
    // any drop restarts the count, so chatter never trips
    assign cnt_nxt = !pif.raw[i] ? '0 :
                     (cnt_r >= thr) ? cnt_r : cnt_r + 7'h01;
    assign pif.filtered[i] = cnt_r >= thr;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_nxt;
      end
    end

    filt_rise_a: assert property (
      @(posedge clk) disable iff (!nrst)
      pif.raw[i] && cnt_r == thr - 7'h01 |=>
        pif.filtered[i] || thr != $past(thr))
      else $error("filter did not fire at its threshold");
    filt_drop_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !pif.raw[i] |=> !pif.filtered[i])
      else $error("filter held after comparator dropped");
  end
endmodule : overcurrent_filter
`default_nettype wire

// [rtl/retry_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module retry_timer #(
  parameter int LONG_CYC = ocp_pkg::RETRY_LONG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // start, stop and expiry
  prot_if.tmr pif
);
  import ocp_pkg::*;

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;
  logic [TMR_W-1:0] load;

  assign load = pif.retry_sel ? TMR_W'(RETRY_SHORT_CYC) : TMR_W'(LONG_CYC);
  assign cnt_nxt = pif.start ? load :
                   pif.stop ? '0 :
                   (cnt_r != '0) ? cnt_r - 16'h0001 : cnt_r;
  assign pif.expired = cnt_r == 16'h0001;
  assign pif.running = cnt_r != '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  load_short_a: assert property (
    @(posedge clk) disable iff (!nrst)
    pif.start && pif.retry_sel |=> cnt_r == TMR_W'(RETRY_SHORT_CYC))
    else $error("short retry interval loaded wrong");
  load_long_a: assert property (
    @(posedge clk) disable iff (!nrst)
    pif.start && !pif.retry_sel |=> cnt_r == TMR_W'(LONG_CYC))
    else $error("long retry interval loaded wrong");
  count_down_a: assert property (
    @(posedge clk) disable iff (!nrst)
    cnt_r > 16'h0001 && !pif.start && !pif.stop |=>
      cnt_r == $past(cnt_r) - 16'h0001)
    else $error("retry timer skipped a count");
endmodule : retry_timer
`default_nettype wire

// [rtl/overcurrent_and_sense_amp_config.sv]
// How it works
// - retry interval 4 ms, or 50 us
// - crossover gap 50/100/200/400 ns, default 100
// - mode 00 latches fault until cleared
// - mode 01 fault clears after retry interval
// - mode 10 reports, drivers untouched
// - mode 11 neither reports nor acts
// - overcurrent must persist 2/4/6/8 us
// - shunt trip level select, default 1 V
// - switch node input forces sense path bit
// - reference halving bit, default halved
// - sense path bit picks plus or minus pin
// - gain 5/10/20/40, default 20
// - shunt fault disable bit masks shunt trips
// - calibrate bits short each amplifier input
// - amplifier register only on amplifier variants
// - both registers read back last write
// - per cycle clear ends retry on pwm
`timescale 1ns/10ps
`default_nettype none
module overcurrent_and_sense_amp_config #(
  parameter logic HAS_AMPS = 1'b1,
  parameter int RETRY_LONG_CYC = ocp_pkg::RETRY_LONG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ocp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // comparators and pwm
  input wire logic drain_source_overcurrent,
  input wire logic shunt_overcurrent,
  input wire logic pwm_input_event,
  // protection outputs
  output logic fault_report,
  output logic drivers_off,
  output logic [2:0] dead_gap_cycles,
  output logic [3:0] drain_source_trip_sel,
  // amplifier settings
  output logic amp_input_select,
  output logic ref_halve,
  output logic low_side_sense_path,
  output logic [1:0] amp_gain_sel,
  output logic amp_a_calibrate,
  output logic amp_b_calibrate,
  output logic amp_c_calibrate,
  output logic [1:0] shunt_trip_sel,
  output logic shunt_fault_disable
);
  import ocp_pkg::*;

  // bus decode
  logic setup;
  logic access;
  logic wr;
  logic aligned;
  logic [IDX_W-1:0] idx;
  logic hit_ocp;
  logic hit_amp;
  logic hit_ctl;
  logic hit_st;
  logic mapped;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign idx = paddr[ADDR_W-1:2];
  assign aligned = paddr[1:0] == 2'b00;
  assign hit_ocp = aligned & (idx == OCP_IDX);
  assign hit_amp = aligned & (idx == AMP_IDX) & HAS_AMPS;
  assign hit_ctl = aligned & (idx == CTL_IDX);
  assign hit_st = aligned & (idx == STAT_IDX);
  assign mapped = hit_ocp | hit_amp | hit_ctl | hit_st;
  // zero wait states; unmapped or absent registers answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // register storage
  logic [10:0] ocp_r;
  logic [10:0] ocp_nxt;
  logic [10:0] amp_r;
  logic [10:0] amp_nxt;
  logic [10:0] amp_wr;
  logic [10:0] amp_fix;
  logic [10:0] ctl_r;
  logic [10:0] ctl_nxt;
  logic clear_req;
  logic per_cycle_clear;

  assign ocp_nxt = (wr & hit_ocp) ? merge11(ocp_r, pwdata, pstrb) : ocp_r;
  assign amp_wr = merge11(amp_r, pwdata, pstrb);
  // the sense path bit is forced to one on every write that sets the input select
  assign amp_fix = amp_wr | (11'(amp_wr[INSEL_BIT]) << LSP_BIT);
  assign amp_nxt = (wr & hit_amp) ? amp_fix : amp_r;
  assign ctl_nxt = (wr & hit_ctl) ?
                   (merge11(ctl_r, pwdata, pstrb) & CTL_MASK) : ctl_r;
  // clear is a strobe and is never stored, so it reads back as zero
  assign clear_req = wr & hit_ctl & pstrb[0] & pwdata[CLR_BIT];
  assign per_cycle_clear = ctl_r[PCC_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ocp_r <= OCP_RST;
      amp_r <= AMP_RST;
      ctl_r <= CTL_RST;
    end else begin
      ocp_r <= ocp_nxt;
      amp_r <= amp_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  // protection datapath
  prot_if pif ();
  overcurrent_response_sel_e mode;
  fault_state_e st_r;
  fault_state_e st_nxt;
  logic trip;
  logic retry_done;
  logic drivers_r;
  logic report_r;
  logic [2:0] dead_gap_r;

  assign mode = overcurrent_response_sel_e'(ocp_r[MODE_LSB +: 2]);
  assign pif.filter_sel = ocp_r[DEG_LSB +: 2];
  assign pif.raw = {shunt_overcurrent, drain_source_overcurrent};
  assign pif.retry_sel = ocp_r[RETRY_BIT];
  // shunt trips are dropped when disabled or when no amplifiers exist
  assign trip = pif.filtered[0] |
                (pif.filtered[1] & ~amp_r[SDIS_BIT] & HAS_AMPS);
  assign retry_done = pif.expired | (per_cycle_clear & pwm_input_event);

  overcurrent_filter u_filter (
    .clk(clk),
    .nrst(nrst),
    .pif(pif.filt)
  );

  retry_timer #(
    .LONG_CYC(RETRY_LONG_CYC)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .pif(pif.tmr)
  );

  // a trip still present at the end of a retry rearms the timer, so the
  // drivers are never released for a single cycle
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_CLEAR: begin
        if (trip && mode == MODE_LATCH) st_nxt = ST_LATCHED;
        else if (trip && mode == MODE_RETRY) st_nxt = ST_RETRY;
      end
      ST_LATCHED: begin
        if (mode != MODE_LATCH || (clear_req && !trip)) st_nxt = ST_CLEAR;
      end
      ST_RETRY: begin
        if (mode != MODE_RETRY || (retry_done && !trip)) st_nxt = ST_CLEAR;
      end
      default: begin
        st_nxt = ST_CLEAR;
      end
    endcase
  end

  assign pif.start = trip & (mode == MODE_RETRY) &
                     ((st_r == ST_CLEAR) | ((st_r == ST_RETRY) & retry_done));
  assign pif.stop = (st_r == ST_RETRY) & (st_nxt == ST_CLEAR);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_CLEAR;
      drivers_r <= 1'b0;
      report_r <= 1'b0;
      dead_gap_r <= DEAD_RST;
    end else begin
      st_r <= st_nxt;
      drivers_r <= st_nxt != ST_CLEAR;
      report_r <= (st_nxt != ST_CLEAR) | ((mode == MODE_REPORT) & trip);
      dead_gap_r <= dead_cycles(ocp_r[DEAD_LSB +: 2]);
    end
  end

  // read path; data is captured in the setup cycle
  logic [31:0] rd_val;
  logic [31:0] prdata_r;
  logic [6:0] stat_v;

  assign stat_v = {drivers_r, report_r, pif.filtered[1], pif.filtered[0],
                   pif.running, st_r == ST_RETRY, st_r == ST_LATCHED};
  assign rd_val = hit_ocp ? {21'h000000, ocp_r} :
                  hit_amp ? {21'h000000, amp_r} :
                  hit_ctl ? {21'h000000, ctl_r} :
                  hit_st ? {25'h0000000, stat_v} : 32'h00000000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= 32'h00000000;
    end else if (setup) begin
      prdata_r <= rd_val;
    end
  end

  // outputs
  assign prdata = prdata_r;
  assign fault_report = report_r;
  assign drivers_off = drivers_r;
  assign dead_gap_cycles = dead_gap_r;
  assign drain_source_trip_sel = ocp_r[DSLVL_LSB +: 4];
  assign amp_input_select = amp_r[INSEL_BIT];
  assign ref_halve = amp_r[HALF_BIT];
  assign low_side_sense_path = amp_r[LSP_BIT];
  assign amp_gain_sel = amp_r[GAIN_LSB +: 2];
  assign amp_a_calibrate = amp_r[CAL_A_BIT];
  assign amp_b_calibrate = amp_r[CAL_B_BIT];
  assign amp_c_calibrate = amp_r[CAL_C_BIT];
  assign shunt_trip_sel = amp_r[SLVL_LSB +: 2];
  assign shunt_fault_disable = amp_r[SDIS_BIT];

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  dead_gap_a: assert property (
    dead_gap_cycles == dead_cycles($past(ocp_r[DEAD_LSB +: 2])))
    else $error("crossover gap does not follow its field");
  latch_hold_a: assert property (
    st_r == ST_LATCHED && mode == MODE_LATCH && !clear_req |=>
      drivers_off && fault_report)
    else $error("latched fault released without a clear");
  latch_clear_a: assert property (
    st_r == ST_LATCHED && mode == MODE_LATCH && clear_req && !trip |=>
      !drivers_off)
    else $error("latched fault ignored its clear");
  retry_end_a: assert property (
    st_r == ST_RETRY && mode == MODE_RETRY && pif.expired && !trip |=>
      !drivers_off && !fault_report)
    else $error("retrying fault outlived its interval");
  retry_len_a: assert property (
    st_r == ST_CLEAR && trip && mode == MODE_RETRY && pif.retry_sel |=>
      drivers_off && pif.running)
    else $error("retrying fault did not start its timer");
  report_only_a: assert property (
    mode == MODE_REPORT && trip && st_r == ST_CLEAR |=>
      fault_report && !drivers_off)
    else $error("report-only mode acted on the drivers");
  silent_mode_a: assert property (
    mode == MODE_SILENT && st_r == ST_CLEAR |=> !fault_report && !drivers_off)
    else $error("silent mode reported or acted");
  amp_force_a: assert property (
    wr && hit_amp && pstrb[1] && pwdata[INSEL_BIT] |=>
      amp_input_select && low_side_sense_path)
    else $error("input select did not force the sense path");
  shunt_mask_a: assert property (
    shunt_fault_disable && !pif.filtered[0] |-> !trip)
    else $error("disabled shunt fault still tripped");
  amp_absent_a: assert property (
    !HAS_AMPS && setup && aligned && idx == AMP_IDX |=> prdata == 32'h00000000)
    else $error("absent amplifier register returned data");
  readback_a: assert property (
    wr && hit_ocp && pstrb[1:0] == 2'b11 |=> ocp_r == $past(pwdata[10:0]))
    else $error("overcurrent settings did not take the write");
  per_cycle_a: assert property (
    st_r == ST_RETRY && mode == MODE_RETRY && per_cycle_clear &&
      pwm_input_event && !trip |=> !drivers_off)
    else $error("pwm input did not end the retrying fault");
  reset_val_a: assert property (
    !$past(nrst) |-> ocp_r == OCP_RST && amp_r == AMP_RST && ctl_r == CTL_RST)
    else $error("register left reset with a wrong value");
  latch_set_a: assert property (
    st_r == ST_CLEAR && trip && mode == MODE_LATCH |=>
      st_r == ST_LATCHED && drivers_off && fault_report)
    else $error("latched fault did not set");
  latch_keep_a: assert property (
    st_r == ST_LATCHED && mode == MODE_LATCH && trip |=>
      st_r == ST_LATCHED)
    else $error("latched fault cleared while trip present");
  retry_again_a: assert property (
    st_r == ST_RETRY && mode == MODE_RETRY && pif.expired && trip |=>
      drivers_off && pif.running)
    else $error("retry expiry released drivers during trip");
  report_drop_a: assert property (
    mode == MODE_REPORT && !trip && st_r == ST_CLEAR |=>
      !fault_report)
    else $error("report-only mode kept reporting");
  mode_leave_a: assert property (
    mode == MODE_REPORT || mode == MODE_SILENT |=>
      !drivers_off)
    else $error("passive mode left drivers off");
  ocp_hold_a: assert property (
    !(wr && hit_ocp) |=> $stable(ocp_r))
    else $error("overcurrent settings changed without a write");
  amp_hold_a: assert property (
    !(wr && hit_amp) |=> $stable(amp_r))
    else $error("amplifier settings changed without a write");
  lane_keep_a: assert property (
    wr && hit_ocp && !pstrb[1] |=>
      ocp_r[10:8] == $past(ocp_r[10:8]))
    else $error("unstrobed lane was written");
  ctl_write_a: assert property (
    wr && hit_ctl && pstrb[0] |=>
      per_cycle_clear == $past(pwdata[PCC_BIT]))
    else $error("per cycle clear did not take the write");
  prdata_hold_a: assert property (
    !setup |=> $stable(prdata))
    else $error("read data moved outside a setup cycle");
  unmapped_err_a: assert property (
    access && aligned && idx == AMP_IDX && !HAS_AMPS |->
      pslverr)
    else $error("absent amplifier register gave no error");
  state_onehot_a: assert property (
    $onehot(st_r))
    else $error("fault state lost its one-hot code");
  drive_report_a: assert property (
    drivers_off |-> fault_report)
    else $error("drivers off without a report");
  shunt_trip_a: assert property (
    HAS_AMPS && !shunt_fault_disable && pif.filtered[1] |->
      trip)
    else $error("enabled shunt fault did not trip");
  amp_clean_a: assert property (
    wr && hit_amp && pstrb[1] && !pwdata[INSEL_BIT] |=>
      low_side_sense_path == $past(pwdata[LSP_BIT]))
    else $error("sense path bit did not take the write");

  latch_trip_c: cover property (st_r == ST_CLEAR ##1 st_r == ST_LATCHED);
  retry_done_c: cover property (st_r == ST_RETRY && pif.expired ##1
                                st_r == ST_CLEAR);
  pwm_clear_c: cover property (st_r == ST_RETRY && per_cycle_clear &&
                               pwm_input_event && !trip);
  report_c: cover property (mode == MODE_REPORT && fault_report);
  retry_again_c: cover property (st_r == ST_RETRY && pif.expired && trip);
endmodule : overcurrent_and_sense_amp_config
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ocp_pkg::*;
  // small long-retry count keeps the run short
  localparam int LONG = 64;
  logic clk, nrst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pready, pslverr, na_err;
  logic drain_source_overcurrent, shunt_overcurrent, pwm_input_event;
  logic fault_report, drivers_off;
  logic [2:0] dead_gap_cycles;
  logic [3:0] drain_source_trip_sel;
  logic amp_input_select, ref_halve, low_side_sense_path, shunt_fault_disable;
  logic amp_a_calibrate, amp_b_calibrate, amp_c_calibrate;
  logic [1:0] amp_gain_sel, shunt_trip_sel, na_gain;
  int n_mismatch = 0;
  int compares = 0;
  logic [32:0] exp_q[$];

  overcurrent_and_sense_amp_config #(.RETRY_LONG_CYC(LONG)) dut (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .drain_source_overcurrent,
    .shunt_overcurrent, .pwm_input_event, .fault_report, .drivers_off,
    .dead_gap_cycles, .drain_source_trip_sel, .amp_input_select,
    .ref_halve, .low_side_sense_path, .amp_gain_sel, .amp_a_calibrate,
    .amp_b_calibrate, .amp_c_calibrate, .shunt_trip_sel,
    .shunt_fault_disable);

  // variant without amplifiers shares the bus and comparators
  overcurrent_and_sense_amp_config #(.HAS_AMPS(1'b0),
    .RETRY_LONG_CYC(LONG)) dut_na (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata(), .pready(), .pslverr(na_err), .drain_source_overcurrent,
    .shunt_overcurrent, .pwm_input_event, .fault_report(), .drivers_off(),
    .dead_gap_cycles(), .drain_source_trip_sel(), .amp_input_select(),
    .ref_halve(), .low_side_sense_path(), .amp_gain_sel(na_gain),
    .amp_a_calibrate(), .amp_b_calibrate(), .amp_c_calibrate(),
    .shunt_trip_sel(), .shunt_fault_disable());

  always #50 clk = ~clk;

  task automatic check(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // one apb transfer; the note is {pslverr, read data}
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
    int t;
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 100);
    if (t >= 100) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic err);
    xfer(1'b1, a, d, {err, 32'h0});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic err);
    xfer(1'b0, a, 32'h0, {err, e});
  endtask : rd

  // program settings, raise drain-source comparator, count to shutdown
  task automatic trip(input logic [10:0] cfg, output int cnt);
    wr(8'h14, {21'h0, cfg}, 1'b0);
    drain_source_overcurrent <= 1'b1;
    cnt = 0;
    while (drivers_off !== 1'b1 && cnt < 300) begin
      @(posedge clk);
      cnt++;
    end
  endtask : trip

  // results are judged where they show up, not where they are asked for
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      check("apb", {pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
      check("na_err", {32'h0, na_err}, {32'h0, pslverr | (paddr == 8'h18)});
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    int cnt;
    int h;
    logic [31:0] d;
    logic [10:0] e;
    logic [7:0] a;
    clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, pwm_input_event} = '0;
    {drain_source_overcurrent, shunt_overcurrent} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    void'($urandom(32'h5efe4526));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    check("dead_rst", 33'(dead_gap_cycles), 33'd1);
    check("amp_rst", 33'({ref_halve, amp_gain_sel, shunt_trip_sel}), 33'h1b);
    rd(8'h14, 32'h159, 1'b0);
    rd(8'h18, 32'h283, 1'b0);
    rd(8'h1c, 32'h001, 1'b0);
    rd(8'h00, 32'h0, 1'b1);
    rd(8'h15, 32'h0, 1'b1);
    wr(8'h24, 32'h7ff, 1'b1);
    // random settings read back; switch-node input forces the path bit
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      a = d[31] ? 8'h18 : 8'h14;
      e = d[10:0];
      if (a == 8'h18 && e[10]) e[8] = 1'b1;
      wr(a, d, 1'b0);
      rd(a, {21'h0, e}, 1'b0);
      if (a == 8'h18) check("amp_out", 33'({amp_input_select, ref_halve,
        low_side_sense_path, amp_gain_sel, shunt_fault_disable,
        amp_a_calibrate, amp_b_calibrate, amp_c_calibrate,
        shunt_trip_sel}), 33'(e));
      else check("ds_trip", 33'(drain_source_trip_sel), 33'(e[3:0]));
    end
    check("na_gain", 33'(na_gain), 33'd2);
    wr(8'h1c, 32'h3, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(8'h14, 32'h059 | (c << 8), 1'b0);
      repeat (3) @(posedge clk);
      h = ((50 << c) + 99) / 100;
      check("dead_gap", 33'(dead_gap_cycles), 33'(h));
    end
    // latched mode at every filter length
    for (int g = 0; g < 4; g++) begin
      trip(11'(32'h509 | (g << 4)), cnt);
      check("filter", 33'(cnt), 33'(20 * (g + 1) + 2));
      drain_source_overcurrent <= 1'b0;
      repeat (10) @(posedge clk);
      rd(8'h20, 32'h61, 1'b0);
      wr(8'h1c, 32'h3, 1'b0);
      repeat (3) @(posedge clk);
      check("latch_clr", 33'(drivers_off), 33'd0);
    end
    // retrying fault lasts the selected interval
    for (int rb = 1; rb >= 0; rb--) begin
      trip(11'(32'h149 | (rb << 10)), cnt);
      drain_source_overcurrent <= 1'b0;
      h = 0;
      while (drivers_off === 1'b1 && h < 1000) begin
        @(posedge clk);
        h++;
      end
      check("retry", 33'(h), 33'(rb ? 500 : LONG));
    end
    // pwm pulse ends retry only with per-cycle clear on
    for (int p = 0; p < 2; p++) begin
      wr(8'h1c, 32'(p), 1'b0);
      trip(11'h549, cnt);
      drain_source_overcurrent <= 1'b0;
      repeat (10) @(posedge clk);
      pwm_input_event <= 1'b1;
      @(posedge clk);
      pwm_input_event <= 1'b0;
      repeat (3) @(posedge clk);
      check("pwm_clr", 33'(drivers_off), 33'(p == 0));
      wr(8'h1c, 32'h1, 1'b0);
      pwm_input_event <= 1'b1;
      @(posedge clk);
      pwm_input_event <= 1'b0;
      repeat (3) @(posedge clk);
    end
    // report-only and silent modes
    for (int m = 2; m < 4; m++) begin
      wr(8'h14, 32'h509 | (m << 6), 1'b0);
      drain_source_overcurrent <= 1'b1;
      repeat (30) @(posedge clk);
      check("report", 33'({fault_report, drivers_off}), 33'(m == 2 ? 2 : 0));
      drain_source_overcurrent <= 1'b0;
      repeat (5) @(posedge clk);
      check("report_end", 33'(fault_report), 33'd0);
    end
    // shunt trip honoured only while enabled
    wr(8'h14, 32'h509, 1'b0);
    for (int s = 1; s >= 0; s--) begin
      wr(8'h18, 32'h283 | (s << 5), 1'b0);
      shunt_overcurrent <= 1'b1;
      repeat (30) @(posedge clk);
      check("shunt", 33'(drivers_off), 33'(s == 0));
      shunt_overcurrent <= 1'b0;
      wr(8'h1c, 32'h3, 1'b0);
    end
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
